// >>> core/bias_adc_pkg.sv
// Constants for the headset bias and capture control register bank.
// Assumes a single 50 MHz clock and the codec's 16-bit register addresses.
package bias_adc_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] BIAS_CTRL_ADDR = 16'h1c03;
    localparam logic [15:0] CAP_CTRL_ADDR  = 16'h1d01;
    localparam logic [15:0] CAP_RAMP_ADDR  = 16'h1d02;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] BIAS_CTRL_RST  = 8'hc2;
    localparam logic [7:0] CAP_CTRL_RST   = 8'h00;
    localparam logic [7:0] CAP_RAMP_RST   = 8'h02;
    localparam logic [7:0] BIAS_CTRL_MASK = 8'h93;
    localparam logic [7:0] CAP_CTRL_MASK  = 8'h35;
    localparam logic [7:0] CAP_RAMP_MASK  = 8'h04;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int NO_CAP_BIT    = 7;
    localparam int PULLDOWN_BIT  = 4;
    localparam int SLEW_MSB      = 1;
    localparam int SLEW_LSB      = 0;
    localparam int NOTCH_OFF_BIT = 5;
    localparam int WEAK_CM_BIT   = 4;
    localparam int POL_FLIP_BIT  = 2;
    localparam int GAIN_LIFT_BIT = 0;
    localparam int GRADUAL_BIT   = 2;

    // ------------------------------------------------------------------
    // Slew codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SLEW_FAST_SLOWFALL = 2'h0;
    localparam logic [1:0] SLEW_FAST          = 2'h1;
    localparam logic [1:0] SLEW_SLOW          = 2'h2;
    localparam logic [1:0] SLEW_SLOWEST       = 2'h3;

    // ------------------------------------------------------------------
    // Ramp delay timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ      = 50_000_000;
    localparam int CYC_PER_MS  = CLK_HZ / 1000;
    localparam int RAMP_MS_00  = 10;
    localparam int RAMP_MS_01  = 40;
    localparam int RAMP_MS_10  = 90;
    localparam int RAMP_MS_11  = 170;
    localparam int TIMER_W     = 24;

endpackage

// >>> core/ramp_delay_timer.sv
// Down counter that times the bias ramp delay.
// Assumes start is a synchronous single-cycle pulse and abort a synchronous level.
`timescale 1ns/1ns
`default_nettype none

module ramp_delay_timer (
    input  wire logic                               ref_clk_in,
    input  wire logic                               srst_in,
    input  wire logic                               start_in,
    input  wire logic                               abort_in,
    input  wire logic [bias_adc_pkg::TIMER_W-1:0]   load_in,
    output logic                                    busy_out,
    output logic                                    done_out
);

    typedef enum logic {T_IDLE, T_COUNT} tstate_e;

    typedef struct packed {
        tstate_e                          st;
        logic [bias_adc_pkg::TIMER_W-1:0] cnt;
        logic                             done;
    } timer_s;

    timer_s q;
    timer_s d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d      = q;
        d.done = 1'b0;
        unique case (q.st)
            T_IDLE: begin
                if (start_in) begin
                    d.st  = T_COUNT;
                    d.cnt = load_in;
                end
            end
            T_COUNT: begin
                if (abort_in) begin
                    d.st = T_IDLE;
                end else if (q.cnt <= 1) begin
                    d.st   = T_IDLE;
                    d.done = 1'b1;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            q <= '{st: T_IDLE, cnt: '0, done: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign busy_out = (q.st == T_COUNT);
    assign done_out = q.done;

endmodule // ramp_delay_timer

`default_nettype wire

// >>> core/headset_bias_adc_ctrl_regs.sv
// Headset bias and capture path control registers with ramp lock.
// Assumes a synchronous register port and synchronous analog status
// inputs from the bias comparators.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Bit 7 no-cap flag, resets to 1
// - Bit 4 enables bias pulldown, reset off
// - Bits 1:0 select bias slew rate
// - Slew field locked during ramp delay
// - Ramp delays 10/40/90/170 ms per code
// - Detect flags valid only after ramp delay
// - Capture bit 5 bypasses notch filter
// - Capture bit 4 forces weak common mode
// - Capture bit 2 inverts capture polarity
// - Capture bit 0 adds 20 dB gain
// - Ramp register bit 2 enables gradual volume
// - Headset flag set when sense below threshold
module headset_bias_adc_ctrl_regs #(
    parameter int unsigned RAMP_CYC_00 =
        bias_adc_pkg::RAMP_MS_00 * bias_adc_pkg::CYC_PER_MS,
    parameter int unsigned RAMP_CYC_01 =
        bias_adc_pkg::RAMP_MS_01 * bias_adc_pkg::CYC_PER_MS,
    parameter int unsigned RAMP_CYC_10 =
        bias_adc_pkg::RAMP_MS_10 * bias_adc_pkg::CYC_PER_MS,
    parameter int unsigned RAMP_CYC_11 =
        bias_adc_pkg::RAMP_MS_11 * bias_adc_pkg::CYC_PER_MS
) (
    input  wire logic        ref_clk_in,
    input  wire logic        srst_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        wr_en_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        rd_en_in,
    output logic      [7:0]  rd_data_out,
    input  wire logic        bias_power_on_in,
    input  wire logic        bias_below_threshold_in,
    input  wire logic        bias_below_short_in,
    output logic             bias_no_cap_flag_out,
    output logic             bias_pulldown_on_out,
    output logic      [1:0]  bias_slew_select_out,
    output logic             ramp_busy_out,
    output logic             detect_valid_out,
    output logic             headset_present_flag_out,
    output logic             short_flag_out,
    output logic             notch_off_out,
    output logic             weak_common_mode_force_out,
    output logic             capture_polarity_flip_out,
    output logic             capture_gain_lift_out,
    output logic             capture_gradual_volume_out
);

    typedef struct packed {
        logic [7:0] bias;
        logic [7:0] cap;
        logic [7:0] ramp;
        logic [7:0] rd;
        logic       pwr;
        logic       valid;
        logic       hs;
        logic       sh;
    } regs_s;

    localparam regs_s RESET_STATE = '{
        bias:  bias_adc_pkg::BIAS_CTRL_RST,
        cap:   bias_adc_pkg::CAP_CTRL_RST,
        ramp:  bias_adc_pkg::CAP_RAMP_RST,
        rd:    8'h00,
        pwr:   1'b0,
        valid: 1'b0,
        hs:    1'b0,
        sh:    1'b0
    };

    regs_s q;
    regs_s d;

    logic                             start;
    logic                             lock;
    logic                             timer_busy;
    logic                             timer_done;
    logic [bias_adc_pkg::TIMER_W-1:0] ramp_load;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [bias_adc_pkg::TIMER_W-1:0] ramp_cycles(
        input logic [1:0] code
    );
        logic [bias_adc_pkg::TIMER_W-1:0] n;
        unique case (code)
            bias_adc_pkg::SLEW_FAST_SLOWFALL:
                n = bias_adc_pkg::TIMER_W'(RAMP_CYC_00);
            bias_adc_pkg::SLEW_FAST:
                n = bias_adc_pkg::TIMER_W'(RAMP_CYC_01);
            bias_adc_pkg::SLEW_SLOW:
                n = bias_adc_pkg::TIMER_W'(RAMP_CYC_10);
            bias_adc_pkg::SLEW_SLOWEST:
                n = bias_adc_pkg::TIMER_W'(RAMP_CYC_11);
        endcase
        return n;
    endfunction

    function automatic logic [7:0] merge(
        input logic [7:0] wdata,
        input logic [7:0] mask,
        input logic [7:0] rst
    );
        return (wdata & mask) | (rst & ~mask);
    endfunction

    // ------------------------------------------------------------------
    // Ramp delay timer
    // ------------------------------------------------------------------
    assign start     = bias_power_on_in & ~q.pwr;
    assign lock      = timer_busy | start;
    assign ramp_load = ramp_cycles(q.bias[bias_adc_pkg::SLEW_MSB:
                                          bias_adc_pkg::SLEW_LSB]);

    ramp_delay_timer u_timer (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .start_in   (start),
        .abort_in   (~bias_power_on_in),
        .load_in    (ramp_load),
        .busy_out   (timer_busy),
        .done_out   (timer_done)
    );

    // ------------------------------------------------------------------
    // Register file and detect gating
    // ------------------------------------------------------------------
    always_comb begin
        d     = q;
        d.pwr = bias_power_on_in;
        if (wr_en_in) begin
            unique case (addr_in)
                bias_adc_pkg::BIAS_CTRL_ADDR: begin
                    d.bias = merge(wr_data_in, bias_adc_pkg::BIAS_CTRL_MASK,
                                   bias_adc_pkg::BIAS_CTRL_RST);
                    if (lock) begin
                        d.bias[1:0] = q.bias[1:0];
                    end
                end
                bias_adc_pkg::CAP_CTRL_ADDR: begin
                    d.cap = merge(wr_data_in, bias_adc_pkg::CAP_CTRL_MASK,
                                  bias_adc_pkg::CAP_CTRL_RST);
                end
                bias_adc_pkg::CAP_RAMP_ADDR: begin
                    d.ramp = merge(wr_data_in, bias_adc_pkg::CAP_RAMP_MASK,
                                   bias_adc_pkg::CAP_RAMP_RST);
                end
                default: begin
                end
            endcase
        end
        if (rd_en_in) begin
            unique case (addr_in)
                bias_adc_pkg::BIAS_CTRL_ADDR: d.rd = q.bias;
                bias_adc_pkg::CAP_CTRL_ADDR:  d.rd = q.cap;
                bias_adc_pkg::CAP_RAMP_ADDR:  d.rd = q.ramp;
                default:                      d.rd = 8'h00;
            endcase
        end
        if (!bias_power_on_in || start) begin
            d.valid = 1'b0;
        end else if (timer_done) begin
            d.valid = 1'b1;
        end
        d.hs = q.valid & bias_below_threshold_in;
        d.sh = q.valid & bias_below_short_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rd_data_out                = q.rd;
    assign bias_no_cap_flag_out       = q.bias[bias_adc_pkg::NO_CAP_BIT];
    assign bias_pulldown_on_out       = q.bias[bias_adc_pkg::PULLDOWN_BIT];
    assign bias_slew_select_out       = q.bias[bias_adc_pkg::SLEW_MSB:
                                               bias_adc_pkg::SLEW_LSB];
    assign ramp_busy_out              = timer_busy;
    assign detect_valid_out           = q.valid;
    assign headset_present_flag_out   = q.hs;
    assign short_flag_out             = q.sh;
    assign notch_off_out              = q.cap[bias_adc_pkg::NOTCH_OFF_BIT];
    assign weak_common_mode_force_out = q.cap[bias_adc_pkg::WEAK_CM_BIT];
    assign capture_polarity_flip_out  = q.cap[bias_adc_pkg::POL_FLIP_BIT];
    assign capture_gain_lift_out      = q.cap[bias_adc_pkg::GAIN_LIFT_BIT];
    assign capture_gradual_volume_out = q.ramp[bias_adc_pkg::GRADUAL_BIT];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [bias_adc_pkg::TIMER_W-1:0] busy_cnt_q;
    logic [bias_adc_pkg::TIMER_W-1:0] expect_q;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            busy_cnt_q <= '0;
            expect_q   <= '0;
        end else if (start) begin
            busy_cnt_q <= '0;
            expect_q   <= ramp_load;
        end else if (timer_busy) begin
            busy_cnt_q <= busy_cnt_q + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    sequence power_rise_s;
        !bias_power_on_in ##1 bias_power_on_in;
    endsequence

    sequence cap_write_s;
        wr_en_in && addr_in == bias_adc_pkg::CAP_CTRL_ADDR;
    endsequence

    no_cap_reset_a: assert property (
        $past(srst_in) |-> bias_no_cap_flag_out && !bias_pulldown_on_out
            && bias_slew_select_out == bias_adc_pkg::SLEW_SLOW)
        else $error("bias control reset value wrong");

    pulldown_write_a: assert property (
        wr_en_in && addr_in == bias_adc_pkg::BIAS_CTRL_ADDR
            |=> bias_pulldown_on_out == $past(wr_data_in[4]))
        else $error("pulldown does not follow write");

    slew_lock_a: assert property (
        power_rise_s |=>
            (ramp_busy_out && $stable(bias_slew_select_out)) [*3])
        else $error("slew not locked after bias power up");

    ramp_length_a: assert property (
        timer_done |-> busy_cnt_q == expect_q)
        else $error("ramp delay length wrong");

    detect_gate_a: assert property (
        !detect_valid_out |=> !headset_present_flag_out && !short_flag_out)
        else $error("detect flag shown before ramp delay done");

    notch_write_a: assert property (
        cap_write_s |=> notch_off_out == $past(wr_data_in[5]))
        else $error("notch bypass does not follow write");

    weak_cm_a: assert property (
        cap_write_s |=> weak_common_mode_force_out == $past(wr_data_in[4]))
        else $error("weak common mode does not follow write");

    polarity_flip_a: assert property (
        cap_write_s |=> capture_polarity_flip_out == $past(wr_data_in[2]))
        else $error("polarity flip does not follow write");

    gain_lift_a: assert property (
        cap_write_s |=> capture_gain_lift_out == $past(wr_data_in[0]))
        else $error("gain lift does not follow write");

    gradual_write_a: assert property (
        wr_en_in && addr_in == bias_adc_pkg::CAP_RAMP_ADDR
            |=> capture_gradual_volume_out == $past(wr_data_in[2]))
        else $error("gradual volume does not follow write");

    headset_flag_a: assert property (
        detect_valid_out && bias_below_threshold_in
            |=> headset_present_flag_out)
        else $error("headset flag missing below threshold");

    reserved_keep_a: assert property (
        (q.bias & ~bias_adc_pkg::BIAS_CTRL_MASK)
            == (bias_adc_pkg::BIAS_CTRL_RST & ~bias_adc_pkg::BIAS_CTRL_MASK)
        && (q.cap & ~bias_adc_pkg::CAP_CTRL_MASK) == 8'h00
        && (q.ramp & ~bias_adc_pkg::CAP_RAMP_MASK)
            == (bias_adc_pkg::CAP_RAMP_RST & ~bias_adc_pkg::CAP_RAMP_MASK))
        else $error("reserved bits changed");

endmodule // headset_bias_adc_ctrl_regs

`default_nettype wire

// >>> bench/headset_bias_adc_ctrl_regs_tb.sv
// Self-checking bench for the headset bias and capture control registers.
// Assumes the design's own assertions run alongside; ramp counts shortened.
`timescale 1ns/1ns
`default_nettype none

module headset_bias_adc_ctrl_regs_tb;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int unsigned RC [4] = '{5, 8, 12, 20};
    localparam int          CEIL   = 3000;

    logic        ref_clk_in;
    logic        srst_in;
    logic [15:0] addr_in;
    logic        wr_en_in;
    logic [7:0]  wr_data_in;
    logic        rd_en_in;
    logic [7:0]  rd_data_out;
    logic        bias_power_on_in;
    logic        bias_below_threshold_in;
    logic        bias_below_short_in;
    logic        bias_no_cap_flag_out;
    logic        bias_pulldown_on_out;
    logic [1:0]  bias_slew_select_out;
    logic        ramp_busy_out;
    logic        detect_valid_out;
    logic        headset_present_flag_out;
    logic        short_flag_out;
    logic        notch_off_out;
    logic        weak_common_mode_force_out;
    logic        capture_polarity_flip_out;
    logic        capture_gain_lift_out;
    logic        capture_gradual_volume_out;
    int          n_mismatch;
    int          tests_run;
    int          cyc = 0;

    headset_bias_adc_ctrl_regs #(
        .RAMP_CYC_00 (RC[0]),
        .RAMP_CYC_01 (RC[1]),
        .RAMP_CYC_10 (RC[2]),
        .RAMP_CYC_11 (RC[3])
    ) u_dut (
        .ref_clk_in                 (ref_clk_in),
        .srst_in                    (srst_in),
        .addr_in                    (addr_in),
        .wr_en_in                   (wr_en_in),
        .wr_data_in                 (wr_data_in),
        .rd_en_in                   (rd_en_in),
        .rd_data_out                (rd_data_out),
        .bias_power_on_in           (bias_power_on_in),
        .bias_below_threshold_in    (bias_below_threshold_in),
        .bias_below_short_in        (bias_below_short_in),
        .bias_no_cap_flag_out       (bias_no_cap_flag_out),
        .bias_pulldown_on_out       (bias_pulldown_on_out),
        .bias_slew_select_out       (bias_slew_select_out),
        .ramp_busy_out              (ramp_busy_out),
        .detect_valid_out           (detect_valid_out),
        .headset_present_flag_out   (headset_present_flag_out),
        .short_flag_out             (short_flag_out),
        .notch_off_out              (notch_off_out),
        .weak_common_mode_force_out (weak_common_mode_force_out),
        .capture_polarity_flip_out  (capture_polarity_flip_out),
        .capture_gain_lift_out      (capture_gain_lift_out),
        .capture_gradual_volume_out (capture_gradual_volume_out)
    );

    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_en_in   <= 1'b1;
        @(posedge ref_clk_in);
        wr_en_in <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a,
                          input logic [7:0] exp);
        @(posedge ref_clk_in);
        addr_in  <= a;
        rd_en_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_en_in <= 1'b0;
        #1;
        chk(what, exp, rd_data_out);
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_values();
        chk("no_cap", 8'h01, {7'h00, bias_no_cap_flag_out});
        chk("pulldown", 8'h00, {7'h00, bias_pulldown_on_out});
        chk("slew", 8'h02, {6'h00, bias_slew_select_out});
        chk("gradual", 8'h00, {7'h00, capture_gradual_volume_out});
        rd_chk("bias_rst", bias_adc_pkg::BIAS_CTRL_ADDR, 8'hc2);
        rd_chk("cap_rst", bias_adc_pkg::CAP_CTRL_ADDR, 8'h00);
        rd_chk("ramp_rst", bias_adc_pkg::CAP_RAMP_ADDR, 8'h02);
        wr(16'h1d03, 8'hff);
        rd_chk("unmapped", 16'h1d03, 8'h00);
        rd_chk("cap_keep", bias_adc_pkg::CAP_CTRL_ADDR, 8'h00);
    endtask

    task automatic capture_bits();
        wr(bias_adc_pkg::CAP_CTRL_ADDR, 8'hff);
        chk("notch", 8'h01, {7'h00, notch_off_out});
        chk("weak_cm", 8'h01, {7'h00, weak_common_mode_force_out});
        chk("pol", 8'h01, {7'h00, capture_polarity_flip_out});
        chk("gain", 8'h01, {7'h00, capture_gain_lift_out});
        rd_chk("cap_ff", bias_adc_pkg::CAP_CTRL_ADDR, 8'h35);
        wr(bias_adc_pkg::CAP_CTRL_ADDR, 8'h24);
        chk("notch2", 8'h01, {7'h00, notch_off_out});
        chk("weak_cm2", 8'h00, {7'h00, weak_common_mode_force_out});
        chk("pol2", 8'h01, {7'h00, capture_polarity_flip_out});
        chk("gain2", 8'h00, {7'h00, capture_gain_lift_out});
        wr(bias_adc_pkg::CAP_RAMP_ADDR, 8'hff);
        chk("grad_on", 8'h01, {7'h00, capture_gradual_volume_out});
        rd_chk("ramp_ff", bias_adc_pkg::CAP_RAMP_ADDR, 8'h06);
    endtask

    task automatic bias_bits();
        wr(bias_adc_pkg::BIAS_CTRL_ADDR, 8'h00);
        chk("no_cap0", 8'h00, {7'h00, bias_no_cap_flag_out});
        rd_chk("bias_00", bias_adc_pkg::BIAS_CTRL_ADDR, 8'h40);
        wr(bias_adc_pkg::BIAS_CTRL_ADDR, 8'hff);
        chk("pulldown1", 8'h01, {7'h00, bias_pulldown_on_out});
        chk("slew3", 8'h03, {6'h00, bias_slew_select_out});
        rd_chk("bias_ff", bias_adc_pkg::BIAS_CTRL_ADDR, 8'hd3);
    endtask

    task automatic ramp_case(input logic [1:0] code);
        int nb;
        int fall;
        nb   = 0;
        fall = -1;
        wr(bias_adc_pkg::BIAS_CTRL_ADDR, {6'h20, code});
        @(posedge ref_clk_in);
        bias_power_on_in        <= 1'b1;
        bias_below_threshold_in <= 1'b1;
        bias_below_short_in     <= 1'b1;
        for (int i = 0; i < int'(RC[code]) + 6; i++) begin
            @(posedge ref_clk_in);
            addr_in    <= bias_adc_pkg::BIAS_CTRL_ADDR;
            wr_data_in <= {6'h24, ~code};
            wr_en_in   <= (i == 2);
            #1;
            if (ramp_busy_out === 1'b1) begin
                nb++;
                chk("valid_busy", 8'h00, {7'h00, detect_valid_out});
                chk("hs_busy", 8'h00,
                    {7'h00, headset_present_flag_out});
            end else if (nb > 0 && fall < 0) begin
                fall = i;
                chk("valid_fall", 8'h00, {7'h00, detect_valid_out});
            end
            if (fall >= 0 && i == fall + 1)
                chk("valid_up", 8'h01, {7'h00, detect_valid_out});
            if (fall >= 0 && i == fall + 2) begin
                chk("hs_up", 8'h01,
                    {7'h00, headset_present_flag_out});
                chk("short_up", 8'h01, {7'h00, short_flag_out});
            end
        end
        chk("ramp_len", RC[code][7:0], nb[7:0]);
        chk("lock", {6'h00, code}, {6'h00, bias_slew_select_out});
        chk("pd_landed", 8'h01, {7'h00, bias_pulldown_on_out});
        @(posedge ref_clk_in);
        bias_below_threshold_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk("hs_gone", 8'h00, {7'h00, headset_present_flag_out});
        @(posedge ref_clk_in);
        bias_power_on_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk("valid_off", 8'h00, {7'h00, detect_valid_out});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        n_mismatch              = 0;
        tests_run               = 0;
        srst_in                 = 1'b1;
        addr_in                 = 16'h0000;
        wr_en_in                = 1'b0;
        wr_data_in              = 8'h00;
        rd_en_in                = 1'b0;
        bias_power_on_in        = 1'b0;
        bias_below_threshold_in = 1'b0;
        bias_below_short_in     = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        @(posedge ref_clk_in);
        #1;
        reset_values();
        capture_bits();
        bias_bits();
        for (int c = 0; c < 4; c++) begin
            ramp_case(c[1:0]);
        end
        tally_and_finish();
    end

endmodule // headset_bias_adc_ctrl_regs_tb

`default_nettype wire
